// File: irq_aux_params.svh
// constants for the event interrupt and auxiliary pin routing block
`ifndef IRQ_AUX_PARAMS_SVH
`define IRQ_AUX_PARAMS_SVH

// ==========================================
// sizes
`define IRQ_SRC_COUNT 11
`define AUX_IN_COUNT 6
`define AUX_OUT_COUNT 3
`define AUX_IN_SEL_W 3
`define AUX_OUT_SEL_W 4
`define AUX_FUNC_COUNT 8

// ==========================================
// interrupt source bit positions
`define SRC_ACQ_RUNNING 0
`define SRC_ACQ_STOP_SEEN 1
`define SRC_ACQ_FINISHED 2
`define SRC_ACQ_FIFO_LEVEL 3
`define SRC_PER_CONVERSION 4
`define SRC_SCAN_END 5
`define SRC_INTERVAL_END 6
`define SRC_WAVE_RUNNING 7
`define SRC_WAVE_FINISHED 8
`define SRC_WAVE_FIFO_LEVEL 9
`define SRC_HIGH_CHANNEL 10

// ==========================================
// reset values
`define IRQ_PENDING_RESET 1'b0
`define AUX_OUT_RESET 3'h0
`define FUNC_RESET 8'h00

// ==========================================
// timing
`define CLK_PERIOD_PS 50000
`define DELAYED_CONVERT_CLOCK_DELAY_PS 100000
`define DELAYED_CONVERT_CLOCK_DELAY_CYC \
  ((`DELAYED_CONVERT_CLOCK_DELAY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// File: irq_aux_pkg.sv
// types for the event interrupt and auxiliary pin routing block
`include "irq_aux_params.svh"

package irq_aux_pkg;

  // ==========================================
  // functions an auxiliary input pin can feed
  typedef enum logic [`AUX_IN_SEL_W-1:0] {
    FN_CONVERT = 3'h0,
    FN_ACQ_TIMEBASE = 3'h1,
    FN_ACQ_START = 3'h2,
    FN_ACQ_STOP = 3'h3,
    FN_ACQ_GATE = 3'h4,
    FN_WAVE_START = 3'h5,
    FN_WAVE_UPDATE = 3'h6,
    FN_WAVE_TIMEBASE = 3'h7
  } aux_in_func_t;

  // ==========================================
  // sources an auxiliary output pin can show
  typedef enum logic [`AUX_OUT_SEL_W-1:0] {
    OS_CONV_BEGIN = 4'h0,
    OS_SAMPLE_HOLD = 4'h1,
    OS_SCAN_STOP = 4'h2,
    OS_CONVERT = 4'h3,
    OS_DELAYED_CONVERT = 4'h4,
    OS_COUNTER_ONE = 4'h5,
    OS_UPDATE = 4'h6,
    OS_COUNTER_TWO = 4'h7,
    OS_ACQ_START = 4'h8,
    OS_ACQ_STOP = 4'h9,
    OS_ACQ_GATE = 4'ha,
    OS_WAVE_START = 4'hb
  } aux_out_src_t;

  // ==========================================
  // sample-hold sequencing, gray coded
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'h0,
    SCAN_HOLD = 2'h1
  } scan_state_t;

  // ==========================================
  // state records
  typedef struct packed {
    logic pending;
  } latch_state_t;

  typedef struct packed {
    scan_state_t scan_state;
    logic [`DELAYED_CONVERT_CLOCK_DELAY_CYC-1:0] conv_shift;
    logic [`AUX_FUNC_COUNT-1:0] func;
    logic stop_prev;
    logic [`AUX_OUT_COUNT-1:0] aux_out;
    logic irq;
  } route_state_t;

endpackage : irq_aux_pkg

// File: event_pending_latch.sv
// one sticky pending flag for an interrupt source
`timescale 1ns/10ps
`default_nettype none
`include "irq_aux_params.svh"

module event_pending_latch
  import irq_aux_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // event and software clear
  input wire logic set,
  input wire logic clear,
  // flag
  output logic pending
);
  import irq_aux_pkg::*;

  latch_state_t s_reg;
  latch_state_t s_next;

  // ==========================================
  // flag logic
  always_comb begin
    s_next = s_reg;
    // set beats clear so an event in the clearing cycle survives
    if (set) begin
      s_next.pending = 1'b1; // [R19]
    end else if (clear) begin
      s_next.pending = 1'b0; // [R19]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg.pending <= `IRQ_PENDING_RESET;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign pending = s_reg.pending;

endmodule : event_pending_latch

`default_nettype wire

// File: daq_event_irq_and_aux_routing.sv
// event interrupt gathering and auxiliary trigger pin routing
// Behaviour
// R1: every enabled pending event drives the host interrupt line low
// R2: each acquisition source has its own software enable bit
// R3: acquisition running sets its flag while a sequence is active
// R4: a rising edge on the routed stop trigger sets its flag
// R5: acquisition finished pulse sets its flag
// R6: conversion fifo at half full sets its flag
// R7: every finished conversion sets its flag
// R8: end of multi-channel scan sets its flag
// R9: end of each inter-scan interval sets its flag
// R10: waveform running sets its flag while generation is active
// R11: waveform finished pulse sets its flag
// R12: output fifo one quarter empty sets its flag
// R13: update of the highest output channel sets its flag
// R14: six configurable input pins and three configurable output pins
// R15: each input pin routes to one of eight timing functions
// R16: each output pin shows one of twelve selectable timing sources
// R17: sample-hold is active in a scan, drops at last conversion start
// R18: delayed convert clock is the convert pulse shifted later
// R19: sticky pending flags until cleared; request is OR of enabled ones
`timescale 1ns/10ps
`default_nettype none
`include "irq_aux_params.svh"

module daq_event_irq_and_aux_routing
  import irq_aux_pkg::*;
#(
  parameter int SRC_COUNT = `IRQ_SRC_COUNT,
  parameter int IN_COUNT = `AUX_IN_COUNT,
  parameter int OUT_COUNT = `AUX_OUT_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // acquisition sequencer events
  input wire logic acq_active,
  input wire logic acq_done,
  input wire logic acq_fifo_half,
  input wire logic conv_done,
  input wire logic scan_done,
  input wire logic interval_done,
  // waveform sequencer events
  input wire logic wave_active,
  input wire logic wave_done,
  input wire logic wave_fifo_quarter_empty,
  input wire logic high_channel_update,
  // timing signals for the output pins
  input wire logic conversion_begin_pulse,
  input wire logic last_channel,
  input wire logic convert_pulse,
  input wire logic update_pulse,
  input wire logic counter_one_clock,
  input wire logic counter_two_clock,
  // interrupt control
  input wire logic [SRC_COUNT-1:0] irq_enable,
  input wire logic [SRC_COUNT-1:0] irq_clear,
  output logic [SRC_COUNT-1:0] irq_pending,
  // host interrupt pin, open drain, active low
  output logic inta_n_out,
  output logic inta_n_oe,
  // auxiliary input pins and routing
  input wire logic [IN_COUNT-1:0] config_trigger_inputs,
  input wire logic [IN_COUNT-1:0] aux_in_en,
  input wire logic [IN_COUNT-1:0][`AUX_IN_SEL_W-1:0] aux_in_sel,
  // routed functions toward the sequencers
  output logic ext_convert,
  output logic ext_acq_timebase,
  output logic ext_acq_start,
  output logic ext_acq_stop,
  output logic ext_acq_gate,
  output logic ext_wave_start,
  output logic ext_wave_update,
  output logic ext_wave_timebase,
  // auxiliary output pins and routing
  input wire logic [OUT_COUNT-1:0] aux_out_en,
  input wire logic [OUT_COUNT-1:0][`AUX_OUT_SEL_W-1:0] aux_out_sel,
  output logic [OUT_COUNT-1:0] config_trigger_outputs,
  output logic [OUT_COUNT-1:0] config_trigger_oe,
  // internally made timing signals
  output logic scan_sample_hold,
  output logic delayed_convert_clock
);
  import irq_aux_pkg::*;

  route_state_t s_reg;
  route_state_t s_next;
  logic [SRC_COUNT-1:0] irq_set;
  logic stop_seen;

  // ==========================================
  // stop trigger edge
  // edge taken on the registered function so a held level counts once
  assign stop_seen = s_reg.func[FN_ACQ_STOP] & ~s_reg.stop_prev; // [R4]

  // ==========================================
  // event gathering
  always_comb begin
    irq_set = '0;
    irq_set[`SRC_ACQ_RUNNING] = acq_active; // [R3]
    irq_set[`SRC_ACQ_STOP_SEEN] = stop_seen; // [R4]
    irq_set[`SRC_ACQ_FINISHED] = acq_done; // [R5]
    // fires at half full, not a quarter as the source name hints
    irq_set[`SRC_ACQ_FIFO_LEVEL] = acq_fifo_half; // [R6]
    irq_set[`SRC_PER_CONVERSION] = conv_done; // [R7]
    irq_set[`SRC_SCAN_END] = scan_done; // [R8]
    irq_set[`SRC_INTERVAL_END] = interval_done; // [R9]
    irq_set[`SRC_WAVE_RUNNING] = wave_active; // [R10]
    irq_set[`SRC_WAVE_FINISHED] = wave_done; // [R11]
    irq_set[`SRC_WAVE_FIFO_LEVEL] = wave_fifo_quarter_empty; // [R12]
    irq_set[`SRC_HIGH_CHANNEL] = high_channel_update; // [R13]
  end

  // ==========================================
  // pending flags
  // level sources keep setting while active, so a clear only sticks
  // once the condition has gone away
  for (genvar i = 0; i < SRC_COUNT; i++) begin : g_pending
    event_pending_latch u_latch (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .set(irq_set[i]), // [R19]
      .clear(irq_clear[i]),
      .pending(irq_pending[i])
    );
  end

  // ==========================================
  // next state
  always_comb begin
    logic [`AUX_FUNC_COUNT-1:0] func_v;
    logic [OUT_COUNT-1:0] out_v;
    logic src_bit;
    func_v = '0;
    out_v = '0;
    src_bit = 1'b0;
    s_next = s_reg;

    // request is the OR of enabled pending flags
    s_next.irq = |(irq_pending & irq_enable); // [R1] [R2] [R19]

    // input routing, several pins on one function are ORed
    for (int p = 0; p < IN_COUNT; p++) begin
      for (int f = 0; f < `AUX_FUNC_COUNT; f++) begin
        if (aux_in_en[p] && aux_in_sel[p] == f[`AUX_IN_SEL_W-1:0]) begin
          func_v[f] = func_v[f] | config_trigger_inputs[p]; // [R14] [R15]
        end
      end
    end
    s_next.func = func_v;
    s_next.stop_prev = s_reg.func[FN_ACQ_STOP];

    // sample-hold sequencing
    case (s_reg.scan_state)
      SCAN_IDLE: begin
        if (conversion_begin_pulse && !last_channel) begin
          s_next.scan_state = SCAN_HOLD; // [R17]
        end
      end
      SCAN_HOLD: begin
        if (conversion_begin_pulse && last_channel) begin
          s_next.scan_state = SCAN_IDLE; // [R17]
        end
      end
      default: begin
        s_next.scan_state = SCAN_IDLE;
      end
    endcase

    // delay line for the convert pulse
    // oldest tap drops out so the line keeps its own width
    s_next.conv_shift = {s_reg.conv_shift[`DELAYED_CONVERT_CLOCK_DELAY_CYC-2:0], convert_pulse}; // [R18]

    // output source selection
    for (int q = 0; q < OUT_COUNT; q++) begin
      case (aux_out_src_t'(aux_out_sel[q]))
        OS_CONV_BEGIN: begin
          src_bit = conversion_begin_pulse; // [R16]
        end
        OS_SAMPLE_HOLD: begin
          src_bit = (s_reg.scan_state == SCAN_HOLD); // [R16] [R17]
        end
        OS_SCAN_STOP: begin
          src_bit = scan_done; // [R16]
        end
        OS_CONVERT: begin
          src_bit = convert_pulse; // [R16]
        end
        OS_DELAYED_CONVERT: begin
          src_bit = s_reg.conv_shift[`DELAYED_CONVERT_CLOCK_DELAY_CYC-1]; // [R16] [R18]
        end
        OS_COUNTER_ONE: begin
          src_bit = counter_one_clock; // [R16]
        end
        OS_UPDATE: begin
          src_bit = update_pulse; // [R16]
        end
        OS_COUNTER_TWO: begin
          src_bit = counter_two_clock; // [R16]
        end
        OS_ACQ_START: begin
          src_bit = s_reg.func[FN_ACQ_START]; // [R16]
        end
        OS_ACQ_STOP: begin
          src_bit = s_reg.func[FN_ACQ_STOP]; // [R16]
        end
        OS_ACQ_GATE: begin
          src_bit = s_reg.func[FN_ACQ_GATE]; // [R16]
        end
        OS_WAVE_START: begin
          src_bit = s_reg.func[FN_WAVE_START]; // [R16]
        end
        // unused codes park the pin low rather than guess a source
        default: begin
          src_bit = 1'b0;
        end
      endcase
      out_v[q] = src_bit & aux_out_en[q]; // [R14] [R16]
    end
    s_next.aux_out = out_v;
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg.scan_state <= SCAN_IDLE;
      s_reg.conv_shift <= '0;
      s_reg.func <= `FUNC_RESET;
      s_reg.stop_prev <= 1'b0;
      s_reg.aux_out <= `AUX_OUT_RESET;
      s_reg.irq <= 1'b0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // outputs
  // open drain: the pin only ever pulls low, never drives high
  assign inta_n_out = 1'b0;
  assign inta_n_oe = s_reg.irq; // [R1]
  assign ext_convert = s_reg.func[FN_CONVERT];
  assign ext_acq_timebase = s_reg.func[FN_ACQ_TIMEBASE];
  assign ext_acq_start = s_reg.func[FN_ACQ_START];
  assign ext_acq_stop = s_reg.func[FN_ACQ_STOP];
  assign ext_acq_gate = s_reg.func[FN_ACQ_GATE];
  assign ext_wave_start = s_reg.func[FN_WAVE_START];
  assign ext_wave_update = s_reg.func[FN_WAVE_UPDATE];
  assign ext_wave_timebase = s_reg.func[FN_WAVE_TIMEBASE];
  assign config_trigger_outputs = s_reg.aux_out;
  assign config_trigger_oe = aux_out_en;
  assign scan_sample_hold = (s_reg.scan_state == SCAN_HOLD); // [R17]
  assign delayed_convert_clock = s_reg.conv_shift[`DELAYED_CONVERT_CLOCK_DELAY_CYC-1]; // [R18]

endmodule : daq_event_irq_and_aux_routing

`default_nettype wire

// File: irq_aux_props.sv
// assertion checker for the event interrupt and aux routing block
`timescale 1ns/10ps
`default_nettype none
`include "irq_aux_params.svh"

// ==========================================
// checker
module irq_aux_props
  import irq_aux_pkg::*;
#(
  parameter int SRC_COUNT = `IRQ_SRC_COUNT,
  parameter int OUT_COUNT = `AUX_OUT_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // event and timing inputs
  input wire logic conv_done,
  input wire logic scan_done,
  input wire logic conversion_begin_pulse,
  input wire logic last_channel,
  input wire logic convert_pulse,
  // interrupt side
  input wire logic [SRC_COUNT-1:0] irq_enable,
  input wire logic [SRC_COUNT-1:0] irq_clear,
  input wire logic [SRC_COUNT-1:0] irq_pending,
  input wire logic inta_n_oe,
  // routing side
  input wire logic ext_acq_stop,
  input wire logic [OUT_COUNT-1:0] aux_out_en,
  input wire logic [OUT_COUNT-1:0][`AUX_OUT_SEL_W-1:0] aux_out_sel,
  input wire logic [OUT_COUNT-1:0] config_trigger_outputs,
  input wire logic [OUT_COUNT-1:0] config_trigger_oe,
  input wire logic scan_sample_hold,
  input wire logic delayed_convert_clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // flag first, then the line one cycle later
  sequence s_oe_follows;
    irq_pending[4] ##1 inta_n_oe;
  endsequence
  property p_walk;
    conv_done && irq_enable[4] ##1 irq_enable[4] |-> s_oe_follows;
  endproperty
  property p_quiet;
    !(|(irq_pending & irq_enable)) |=> !inta_n_oe;
  endproperty
  property p_sticky;
    1'b1 |=> ($past(irq_pending) & ~$past(irq_clear) & ~irq_pending) == '0;
  endproperty
  property p_clear;
    irq_clear[5] && !scan_done |=> !irq_pending[5];
  endproperty
  property p_stop;
    $rose(ext_acq_stop) |=> irq_pending[1];
  endproperty
  property p_hold;
    conversion_begin_pulse |=> scan_sample_hold == !$past(last_channel);
  endproperty
  property p_delay;
    1'b1 |-> delayed_convert_clock == $past(convert_pulse, 2);
  endproperty
  property p_out;
    aux_out_en[0] && aux_out_sel[0] == OS_CONVERT
      |=> config_trigger_outputs[0] == $past(convert_pulse);
  endproperty
  property p_oe;
    1'b1 |=> config_trigger_oe == aux_out_en
      && (config_trigger_outputs & ~$past(aux_out_en)) == '0;
  endproperty

  a_walk: assert property (p_walk) else $error("line did not follow flag");
  a_quiet: assert property (p_quiet) else $error("line driven with nothing pending");
  a_sticky: assert property (p_sticky) else $error("flag dropped uncleared");
  a_clear: assert property (p_clear) else $error("clear ignored");
  a_stop: assert property (p_stop) else $error("stop edge not latched");
  a_hold: assert property (p_hold) else $error("sample hold wrong");
  a_delay: assert property (p_delay) else $error("delayed clock wrong");
  a_out: assert property (p_out) else $error("output pin wrong");
  a_oe: assert property (p_oe) else $error("output enable wrong");
endmodule : irq_aux_props

bind daq_event_irq_and_aux_routing irq_aux_props #(
  .SRC_COUNT(SRC_COUNT),
  .OUT_COUNT(OUT_COUNT)
) irq_aux_props_inst (
  .clk, .reset_n, .conv_done, .scan_done, .conversion_begin_pulse, .last_channel,
  .convert_pulse, .irq_enable, .irq_clear, .irq_pending, .inta_n_oe, .ext_acq_stop,
  .aux_out_en, .aux_out_sel, .config_trigger_outputs, .config_trigger_oe,
  .scan_sample_hold, .delayed_convert_clock
);
`default_nettype wire

// File: host_irq_line.sv
// host side model of the shared open drain interrupt line
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// pulled-up line as the host sees it
module host_irq_line (
  // from the block
  input wire logic inta_n_out,
  input wire logic inta_n_oe,
  // host view
  output logic irq_seen
);
  // pull-up wins whenever nobody drives the line
  assign irq_seen = !(inta_n_oe ? inta_n_out : 1'b1);
endmodule : host_irq_line
`default_nettype wire

// File: testbench.sv
// self-checking bench for the event interrupt and aux routing block
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// bench
module testbench;
  import irq_aux_pkg::*;
  logic clk = 0, reset_n = 0, cbp = 0, lastc = 0, cvp = 0, upd = 0, c1 = 0, c2 = 0;
  logic [10:0] ev = '0, en = '0, clr = '0, pend;
  logic [5:0] pins = '0, ien = '0;
  logic [5:0][2:0] isel = '0;
  logic [2:0] oen = '0, ctout, ctoe;
  logic [2:0][3:0] osel = '0;
  logic [7:0] ext, xe;
  logic [2:0][1:0] xo;
  logic int_out, int_oe, sh, dcc, seen;
  int error_cnt = 0, comparisons = 0;

  always #25 clk = ~clk;

  // ev[1] unused: the stop flag comes only through a routed pin
  daq_event_irq_and_aux_routing daq_event_irq_and_aux_routing_inst (
    .clk(clk), .reset_n(reset_n), .clk_en(1'b1), .acq_active(ev[0]), .acq_done(ev[2]),
    .acq_fifo_half(ev[3]), .conv_done(ev[4]), .scan_done(ev[5]), .interval_done(ev[6]),
    .wave_active(ev[7]), .wave_done(ev[8]), .wave_fifo_quarter_empty(ev[9]),
    .high_channel_update(ev[10]), .conversion_begin_pulse(cbp), .last_channel(lastc),
    .convert_pulse(cvp), .update_pulse(upd), .counter_one_clock(c1), .counter_two_clock(c2),
    .irq_enable(en), .irq_clear(clr), .irq_pending(pend), .inta_n_out(int_out),
    .inta_n_oe(int_oe), .config_trigger_inputs(pins), .aux_in_en(ien), .aux_in_sel(isel),
    .ext_convert(ext[0]), .ext_acq_timebase(ext[1]), .ext_acq_start(ext[2]),
    .ext_acq_stop(ext[3]), .ext_acq_gate(ext[4]), .ext_wave_start(ext[5]),
    .ext_wave_update(ext[6]), .ext_wave_timebase(ext[7]), .aux_out_en(oen),
    .aux_out_sel(osel), .config_trigger_outputs(ctout), .config_trigger_oe(ctoe),
    .scan_sample_hold(sh), .delayed_convert_clock(dcc)
  );
  host_irq_line host_irq_line_inst (.inta_n_out(int_out), .inta_n_oe(int_oe), .irq_seen(seen));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [7:0] route_fn(input logic [5:0] p, e, input logic [5:0][2:0] s);
    route_fn = '0;
    for (int i = 0; i < 6; i++) if (p[i] && e[i]) route_fn[s[i]] = 1'b1;
  endfunction : route_fn

  // {known, value}; internally made sources are left to the checker
  function automatic logic [1:0] out_fn(input logic [3:0] s);
    case (s)
      4'h0: out_fn = {1'b1, cbp};
      4'h2: out_fn = {1'b1, ev[5]};
      4'h3: out_fn = {1'b1, cvp};
      4'h5: out_fn = {1'b1, c1};
      4'h6: out_fn = {1'b1, upd};
      4'h7: out_fn = {1'b1, c2};
      default: out_fn = {s > 4'hb, 1'b0};
    endcase
  endfunction : out_fn

  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(76));
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    check({pend, seen}, '0);
    ien[2] = 1'b1;
    isel[2] = FN_ACQ_STOP;
    // each source in turn: latch disabled, enable, then clear
    for (int i = 0; i < 11; i++) begin
      if (i == 1) pins[2] = 1'b1; else ev[i] = 1'b1;
      @(negedge clk);
      ev = '0;
      pins = '0;
      repeat (3) @(negedge clk);
      check(pend, 16'(1) << i);
      check(seen, 0);
      en[i] = 1'b1;
      repeat (2) @(negedge clk);
      check(seen, 1);
      clr[i] = 1'b1;
      @(negedge clk);
      clr = '0;
      @(negedge clk);
      check({pend, seen}, 0);
      en = '0;
    end
    // enabled event: flag next cycle, line the cycle after
    en[4] = 1'b1;
    ev[4] = 1'b1;
    @(negedge clk);
    ev = '0;
    check(pend[4], 1);
    @(negedge clk);
    check(seen, 1);
    clr[4] = 1'b1;
    @(negedge clk);
    clr = '0;
    en = '0;
    // scan sample-hold: raised mid-scan, dropped at the last conversion
    cbp = 1'b1;
    @(negedge clk);
    cbp = 1'b0;
    @(negedge clk);
    check(sh, 1);
    {cbp, lastc} = 2'h3;
    @(negedge clk);
    {cbp, lastc} = 2'h0;
    @(negedge clk);
    check(sh, 0);
    cvp = 1'b1;
    @(negedge clk);
    cvp = 1'b0;
    check(dcc, 0);
    @(negedge clk);
    check(dcc, 1);
    @(negedge clk);
    check(dcc, 0);
    // random routing, first pass every pin on one function
    for (int k = 0; k < 60; k++) begin
      {pins, ien, isel} = 30'($urandom);
      {oen, osel} = 15'($urandom);
      {cbp, lastc, cvp, upd, c1, c2, ev[5]} = 7'($urandom);
      en = 11'($urandom);
      if (k == 0) begin
        {pins, ien, isel} = {12'hfff, 18'h0};
      end
      xe = route_fn(pins, ien, isel);
      for (int j = 0; j < 3; j++) xo[j] = out_fn(osel[j]);
      @(negedge clk);
      check(ext, xe);
      check(ctoe, oen);
      for (int j = 0; j < 3; j++) if (xo[j][1] || !oen[j]) check(ctout[j], xo[j][0] & oen[j]);
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
